// ### hw/tlhb_regs.svh
// Offsets, field positions, reset values and layout figures of the chain block.
// Assumes inclusion by bare name from the design modules.
`ifndef TLHB_REGS_SVH
`define TLHB_REGS_SVH

// Control block byte offsets
`define TLHB_CB_RX_HEAD_HIGH 4'h0
`define TLHB_CB_RX_HEAD_LOW 4'h1
`define TLHB_CB_TX_HEAD_HIGH 4'h2
`define TLHB_CB_TX_HEAD_LOW 4'h3
`define TLHB_CB_BUFFER_SIZE_CODE 4'h4
`define TLHB_CB_EVENT_COUNT_FIRST 4'h5
`define TLHB_CB_EVENT_COUNT_SECOND 4'h6
`define TLHB_CB_EVENT_COUNT_ELEVENTH 4'hf
`define TLHB_CB_FETCH_LAST 4'h4

// Host register port offsets
`define TLHB_REG_CONTROL 4'h0
`define TLHB_REG_CBP_HIGH 4'h1
`define TLHB_REG_CBP_LOW 4'h2
`define TLHB_REG_IRQ 4'h3
`define TLHB_REG_STATUS 4'h4

// Control register fields
`define TLHB_CTL_ISOLATE 0
`define TLHB_CTL_NEW_NEXT_ADDRESS_REQUEST 1
`define TLHB_CTL_INHIBIT 2
`define TLHB_CTL_RESET 8'h01

// Buffer layout figures
`define TLHB_SIZE_UNIT 11'h040
`define TLHB_LINK_BYTES 11'h002
`define TLHB_FRAME_OVH 8'h06
`define TLHB_BOUND_OVH 8'h02
`define TLHB_MAX_BUFS 5'h10
`define TLHB_EVT_MAX 8'hff
`define TLHB_NUM_EVT 11

`endif

// ### hw/tlhb_pkg.sv
// Types shared by the chain follower, its memory model and its bench.
// Assumes the offsets header sits beside it.
package tlhb_pkg;

    // Single DMA byte request toward host memory
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } tlhb_mem_req_t;

    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_ISO = 7'h01,
        ST_CB_RD = 7'h02,
        ST_RUN = 7'h04,
        ST_LNK_H = 7'h08,
        ST_LNK_L = 7'h10,
        ST_CNT_RD = 7'h20,
        ST_CNT_WR = 7'h40
    } tlhb_state_t;

endpackage

// ### hw/tlhb_chain_ptr.sv
// Next-address tracker for one buffer chain, with its state flag and
// a count of buffers taken by the current frame.
// Assumes update and frame-end strobes come from logic on the same clock.
`timescale 1ns/1ns
`include "tlhb_regs.svh"
module tlhb_chain_ptr (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_upd,
    input wire logic [15:0] i_upd_addr,
    input wire logic i_upd_flag,
    input wire logic i_take,
    input wire logic i_frame_end,
    output logic [15:0] o_next,
    output logic o_flag,
    output logic [4:0] o_bufs
);
    logic [15:0] next_ff;
    logic [15:0] nxt_next;
    logic flag_ff;
    logic nxt_flag;
    logic [4:0] bufs_ff;
    logic [4:0] nxt_bufs;

    // Next state; a take in the frame-end cycle starts the new frame's count
    always_comb
    begin
        nxt_next = next_ff;
        nxt_flag = flag_ff;
        nxt_bufs = bufs_ff;
        if (i_upd)
        begin
            nxt_next = i_upd_addr;
            nxt_flag = i_upd_flag;
        end
        if (i_frame_end)
            nxt_bufs = 5'h00;
        if (i_take)
            nxt_bufs = (i_frame_end ? 5'h00 : bufs_ff) + 5'h01;
        if (bufs_ff == 5'h1f && !i_frame_end)
            nxt_bufs = bufs_ff; // Saturate, overflow stays visible
    end

    // Registers
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            next_ff <= 16'h0000;
            flag_ff <= 1'b0;
            bufs_ff <= 5'h00;
        end
        else
        begin
            next_ff <= nxt_next;
            flag_ff <= nxt_flag;
            bufs_ff <= nxt_bufs;
        end
    end

    assign o_next = next_ff;
    assign o_flag = flag_ff;
    assign o_bufs = bufs_ff;
endmodule

// ### hw/tlhb_top.sv
// Host-memory side of a token network controller: fetches the control
// block, follows receive and transmit buffer chains, bumps event counters.
// Assumes host port, memory port and network strobes share i_ref_clk.
`timescale 1ns/1ns
`include "tlhb_regs.svh"
module tlhb_top (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output tlhb_pkg::tlhb_mem_req_t o_mem,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [1:0] i_chain_adv,
    input wire logic [1:0] i_chain_poll,
    input wire logic [1:0] i_frame_end,
    input wire logic [10:0] i_evt,
    output logic o_interrupt_output,
    output logic [10:0] o_buf_bytes,
    output logic [10:0] o_buf_payload,
    output logic [15:0] o_rx_next,
    output logic [15:0] o_tx_next,
    output logic o_rx_next_valid_flag,
    output logic o_tx_next_valid_flag,
    output logic [7:0] o_rx_frame_ovh,
    output logic [1:0] o_frame_overflow
);
    // ********************************************************
    // Declarations
    // ********************************************************
    tlhb_pkg::tlhb_state_t st_ff, nxt_st;
    tlhb_pkg::tlhb_mem_req_t mem_ff, nxt_mem;
    logic [7:0] ctl_ff, nxt_ctl;
    logic [7:0] cbp_h_ff, nxt_cbp_h, cbp_l_ff, nxt_cbp_l;
    logic [1:0] irq_ff, nxt_irq;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] cb_ff [0:4];
    logic [7:0] nxt_cb [0:4];
    logic [3:0] idx_ff, nxt_idx;
    logic [7:0] lnk_h_ff, nxt_lnk_h;
    logic sel_ff, nxt_sel;
    logic [1:0] adv_ff, nxt_adv, poll_ff, nxt_poll;
    logic [10:0] evt_ff, nxt_evt;
    logic [3:0] evn_ff, nxt_evn;
    logic interrupt_output_ff, nxt_interrupt_output;
    logic [10:0] bytes_ff, nxt_bytes, pay_ff, nxt_pay;
    logic [7:0] ovh_ff, nxt_ovh;
    logic [1:0] ovf_ff, nxt_ovf;
    logic [1:0] upd, take, flag;
    logic [15:0] upd_addr [0:1];
    logic [15:0] next_a [0:1];
    logic [4:0] bufs [0:1];
    logic [1:0] upd_flag;
    logic [15:0] cbp, link;
    logic [3:0] pick;
    logic host_new_next_address_request;

    assign cbp = {cbp_h_ff, cbp_l_ff};
    assign link = {lnk_h_ff, i_mem_rdata};
    // Host setting new-next-address in this cycle
    assign host_new_next_address_request = i_reg_wr && i_reg_addr == `TLHB_REG_CONTROL && i_reg_wdata[`TLHB_CTL_NEW_NEXT_ADDRESS_REQUEST];

    // ********************************************************
    // Per-chain trackers, rx is chain 0 and tx chain 1
    // ********************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_chain
            tlhb_chain_ptr u_ptr (
                .i_ref_clk(i_ref_clk),
                .i_resetn(i_resetn),
                .i_upd(upd[g]),
                .i_upd_addr(upd_addr[g]),
                .i_upd_flag(upd_flag[g]),
                .i_take(take[g]),
                .i_frame_end(i_frame_end[g]),
                .o_next(next_a[g]),
                .o_flag(flag[g]),
                .o_bufs(bufs[g])
            );
        end
    endgenerate

    // Lowest pending event wins the counter slot
    always_comb
    begin
        pick = 4'h0;
        for (int i = `TLHB_NUM_EVT - 1; i >= 0; i--)
            if (evt_ff[i])
                pick = 4'(i);
    end

    // ********************************************************
    // Sequencer and register next state
    // ********************************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_mem = mem_ff;
        nxt_ctl = ctl_ff;
        nxt_cbp_h = cbp_h_ff;
        nxt_cbp_l = cbp_l_ff;
        nxt_cb = cb_ff;
        nxt_idx = idx_ff;
        nxt_lnk_h = lnk_h_ff;
        nxt_sel = sel_ff;
        nxt_evn = evn_ff;
        nxt_rdata = rdata_ff;
        upd = 2'b00;
        take = 2'b00;
        upd_flag = 2'b00;
        upd_addr[0] = next_a[0];
        upd_addr[1] = next_a[1];
        // Pending work is sticky so a request in a busy cycle is kept
        nxt_adv = adv_ff | i_chain_adv;
        nxt_poll = poll_ff | i_chain_poll;
        nxt_evt = evt_ff | i_evt;
        nxt_irq = irq_ff;
        // Host owns isolate and inhibit; new-next-address is set-only here
        if (i_reg_wr && i_reg_addr == `TLHB_REG_CONTROL)
        begin
            nxt_ctl[`TLHB_CTL_ISOLATE] = i_reg_wdata[`TLHB_CTL_ISOLATE];
            nxt_ctl[`TLHB_CTL_INHIBIT] = i_reg_wdata[`TLHB_CTL_INHIBIT];
            if (i_reg_wdata[`TLHB_CTL_NEW_NEXT_ADDRESS_REQUEST])
                nxt_ctl[`TLHB_CTL_NEW_NEXT_ADDRESS_REQUEST] = 1'b1;
        end
        if (i_reg_wr && st_ff == tlhb_pkg::ST_ISO && i_reg_addr == `TLHB_REG_CBP_HIGH)
            nxt_cbp_h = i_reg_wdata;
        if (i_reg_wr && st_ff == tlhb_pkg::ST_ISO && i_reg_addr == `TLHB_REG_CBP_LOW)
            nxt_cbp_l = i_reg_wdata;
        // Host clears irq bits by writing ones; it never sets them
        if (i_reg_wr && i_reg_addr == `TLHB_REG_IRQ)
            nxt_irq = irq_ff & ~i_reg_wdata[1:0];
        case (st_ff)
            tlhb_pkg::ST_ISO:
            begin
                nxt_adv = 2'b00;
                nxt_poll = 2'b00;
                if (!ctl_ff[`TLHB_CTL_ISOLATE])
                begin
                    nxt_st = tlhb_pkg::ST_CB_RD;
                    nxt_idx = 4'h0;
                    nxt_mem = '{req: 1'b1, we: 1'b0, addr: cbp, wdata: 8'h00};
                end
            end
            tlhb_pkg::ST_CB_RD:
            begin
                if (i_mem_ack)
                begin
                    nxt_cb[idx_ff[2:0]] = i_mem_rdata;
                    nxt_idx = idx_ff + 4'h1;
                    nxt_mem.addr = cbp + {12'h000, idx_ff + 4'h1};
                    if (idx_ff == `TLHB_CB_FETCH_LAST)
                    begin
                        // Zero head: watch the control block entry itself
                        upd = 2'b11;
                        upd_addr[0] = {cb_ff[0], cb_ff[1]};
                        upd_addr[1] = {cb_ff[2], cb_ff[3]};
                        upd_flag[0] = (upd_addr[0] != 16'h0000);
                        upd_flag[1] = (upd_addr[1] != 16'h0000);
                        if (!upd_flag[0])
                            upd_addr[0] = cbp + {12'h000, `TLHB_CB_RX_HEAD_HIGH};
                        if (!upd_flag[1])
                            upd_addr[1] = cbp + {12'h000, `TLHB_CB_TX_HEAD_HIGH};
                        nxt_mem.req = 1'b0;
                        nxt_st = tlhb_pkg::ST_RUN;
                    end
                end
            end
            tlhb_pkg::ST_RUN:
            begin
                // One access at a time, isolation only between accesses
                if (ctl_ff[`TLHB_CTL_ISOLATE])
                    nxt_st = tlhb_pkg::ST_ISO;
                else if (ctl_ff[`TLHB_CTL_NEW_NEXT_ADDRESS_REQUEST])
                begin
                    nxt_poll = poll_ff | i_chain_poll | 2'b11;
                    // A fresh host set in the same cycle wins, else that request is lost
                    if (!host_new_next_address_request)
                        nxt_ctl[`TLHB_CTL_NEW_NEXT_ADDRESS_REQUEST] = 1'b0;
                end
                else if ((adv_ff | poll_ff) != 2'b00)
                begin
                    // Rx first; the transmit side is less urgent
                    nxt_sel = !(adv_ff[0] | poll_ff[0]);
                    nxt_mem = '{req: 1'b1, we: 1'b0, addr: next_a[nxt_sel], wdata: 8'h00};
                    nxt_st = tlhb_pkg::ST_LNK_H;
                end
                else if (evt_ff != 11'h000)
                begin
                    nxt_evn = pick;
                    nxt_mem = '{req: 1'b1, we: 1'b0,
                        addr: cbp + {12'h000, `TLHB_CB_EVENT_COUNT_FIRST + pick}, wdata: 8'h00};
                    nxt_st = tlhb_pkg::ST_CNT_RD;
                end
            end
            tlhb_pkg::ST_LNK_H:
            begin
                if (i_mem_ack)
                begin
                    nxt_lnk_h = i_mem_rdata;
                    nxt_mem.addr = mem_ff.addr + 16'h0001;
                    nxt_st = tlhb_pkg::ST_LNK_L;
                end
            end
            tlhb_pkg::ST_LNK_L:
            begin
                if (i_mem_ack)
                begin
                    nxt_mem.req = 1'b0;
                    nxt_st = tlhb_pkg::ST_RUN;
                    nxt_adv[sel_ff] = i_chain_adv[sel_ff];
                    nxt_poll[sel_ff] = i_chain_poll[sel_ff];
                    take[sel_ff] = adv_ff[sel_ff] & flag[sel_ff];
                    upd_addr[sel_ff] = link;
                    upd_flag[sel_ff] = 1'b1;
                    if (link != 16'h0000)
                        upd[sel_ff] = 1'b1;
                    else if (take[sel_ff])
                    begin
                        // Entered a buffer whose link is zero
                        upd[sel_ff] = 1'b1;
                        upd_addr[sel_ff] = next_a[sel_ff];
                        upd_flag[sel_ff] = 1'b0;
                    end
                    if (upd[sel_ff])
                        nxt_irq[sel_ff] = 1'b1;
                end
            end
            tlhb_pkg::ST_CNT_RD:
            begin
                if (i_mem_ack)
                begin
                    nxt_mem.we = (i_mem_rdata != `TLHB_EVT_MAX);
                    nxt_mem.req = nxt_mem.we;
                    nxt_mem.wdata = i_mem_rdata + 8'h01;
                    nxt_evt[evn_ff] = i_evt[evn_ff];
                    nxt_st = nxt_mem.we ? tlhb_pkg::ST_CNT_WR : tlhb_pkg::ST_RUN;
                end
            end
            tlhb_pkg::ST_CNT_WR:
            begin
                if (i_mem_ack)
                begin
                    nxt_mem.req = 1'b0;
                    nxt_mem.we = 1'b0;
                    nxt_st = tlhb_pkg::ST_RUN;
                end
            end
            default:
            begin
                nxt_mem.req = 1'b0;
                nxt_st = tlhb_pkg::ST_ISO;
            end
        endcase
        // Status reads show the controller's own state
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                `TLHB_REG_CONTROL: nxt_rdata = ctl_ff;
                `TLHB_REG_CBP_HIGH: nxt_rdata = cbp_h_ff;
                `TLHB_REG_CBP_LOW: nxt_rdata = cbp_l_ff;
                `TLHB_REG_IRQ: nxt_rdata = {6'h00, irq_ff};
                `TLHB_REG_STATUS: nxt_rdata = {5'h00, st_ff == tlhb_pkg::ST_ISO, flag};
                default: nxt_rdata = 8'h00;
            endcase
        end
        nxt_interrupt_output = (nxt_irq != 2'b00) && !nxt_ctl[`TLHB_CTL_INHIBIT];
        nxt_bytes = ({7'h00, cb_ff[4][3:0]} + 11'h001) * `TLHB_SIZE_UNIT;
        nxt_pay = bytes_ff - `TLHB_LINK_BYTES;
        nxt_ovh = `TLHB_FRAME_OVH;
        if (bufs[0] > 5'h01)
            nxt_ovh = `TLHB_FRAME_OVH + `TLHB_BOUND_OVH * {3'h0, bufs[0] - 5'h01};
        nxt_ovf = {bufs[1] > `TLHB_MAX_BUFS, bufs[0] > `TLHB_MAX_BUFS};
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_ff <= tlhb_pkg::ST_ISO;
            mem_ff <= '0;
            ctl_ff <= `TLHB_CTL_RESET;
            cbp_h_ff <= 8'h00;
            cbp_l_ff <= 8'h00;
            irq_ff <= 2'b00;
            rdata_ff <= 8'h00;
            for (int i = 0; i < 5; i++)
                cb_ff[i] <= 8'h00;
            idx_ff <= 4'h0;
            lnk_h_ff <= 8'h00;
            sel_ff <= 1'b0;
            adv_ff <= 2'b00;
            poll_ff <= 2'b00;
            evt_ff <= 11'h000;
            evn_ff <= 4'h0;
            interrupt_output_ff <= 1'b0;
            bytes_ff <= `TLHB_SIZE_UNIT;
            pay_ff <= 11'h000;
            ovh_ff <= 8'h00;
            ovf_ff <= 2'b00;
        end
        else
        begin
            st_ff <= nxt_st;
            mem_ff <= nxt_mem;
            ctl_ff <= nxt_ctl;
            cbp_h_ff <= nxt_cbp_h;
            cbp_l_ff <= nxt_cbp_l;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
            cb_ff <= nxt_cb;
            idx_ff <= nxt_idx;
            lnk_h_ff <= nxt_lnk_h;
            sel_ff <= nxt_sel;
            adv_ff <= nxt_adv;
            poll_ff <= nxt_poll;
            evt_ff <= nxt_evt;
            evn_ff <= nxt_evn;
            interrupt_output_ff <= nxt_interrupt_output;
            bytes_ff <= nxt_bytes;
            pay_ff <= nxt_pay;
            ovh_ff <= nxt_ovh;
            ovf_ff <= nxt_ovf;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_mem = mem_ff;
    assign o_interrupt_output = interrupt_output_ff;
    assign o_buf_bytes = bytes_ff;
    assign o_buf_payload = pay_ff;
    assign o_rx_next = next_a[0];
    assign o_tx_next = next_a[1];
    assign o_rx_next_valid_flag = flag[0];
    assign o_tx_next_valid_flag = flag[1];
    assign o_rx_frame_ovh = ovh_ff;
    assign o_frame_overflow = ovf_ff;

    // ********************************************************
    // Assertions
    // ********************************************************
    logic [15:0] off;
    assign off = mem_ff.addr - cbp;
    sequence s_fetch_done;
        st_ff == tlhb_pkg::ST_CB_RD && i_mem_ack && idx_ff == `TLHB_CB_FETCH_LAST;
    endsequence

    a_cbp_locked: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_reg_wr && st_ff != tlhb_pkg::ST_ISO) |=> $stable(cbp))
        else $error("pointer changed outside isolation");
    a_fetch_five: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        st_ff == tlhb_pkg::ST_CB_RD |-> (!mem_ff.we && off < 16'h0005))
        else $error("block fetch out of range");
    a_zero_head: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        s_fetch_done |=> (flag[0] == ({cb_ff[0], cb_ff[1]} != 16'h0000)))
        else $error("rx flag wrong after fetch");
    a_counter_only: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (mem_ff.req && (st_ff == tlhb_pkg::ST_CNT_RD || st_ff == tlhb_pkg::ST_CNT_WR))
        |-> (off >= 16'h0005 && off <= 16'h000f))
        else $error("counter access off range");
    a_no_origin: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (mem_ff.req && mem_ff.we) |-> off >= 16'h0005)
        else $error("origin entry written");
    a_cnt_sat: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (st_ff == tlhb_pkg::ST_CNT_WR && mem_ff.req) |-> mem_ff.wdata != 8'h00)
        else $error("counter wrapped");
    a_irq_out: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (irq_ff != 2'b00 && !ctl_ff[`TLHB_CTL_INHIBIT]) |-> o_interrupt_output)
        else $error("interrupt not driven");
    a_adv_irq: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (st_ff == tlhb_pkg::ST_LNK_L && i_mem_ack && link != 16'h0000)
        |=> (irq_ff[sel_ff] && flag[sel_ff]))
        else $error("advance without event");
    a_size_range: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        ##1 (o_buf_bytes >= 11'h040 && o_buf_bytes <= 11'h400 && o_buf_bytes[5:0] == 6'h00))
        else $error("buffer size out of range");
endmodule

// ### test/tlhb_mem_model.sv
// Host memory model that answers the chain block's byte requests.
// Assumes each request is held until acked, one byte per access.
`timescale 1ns/1ns
module tlhb_mem_model (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire tlhb_pkg::tlhb_mem_req_t i_mem,
    input wire logic [1:0] i_lat,
    output logic o_mem_ack,
    output logic [7:0] o_mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_ff;
    // Ack after i_lat idle cycles; data lines scramble except on a read ack
    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_mem_ack <= 1'b0;
            wait_ff <= 2'h0;
            o_mem_rdata <= 8'h00;
        end
        else if (i_mem.req && !o_mem_ack && wait_ff >= i_lat)
        begin
            o_mem_ack <= 1'b1;
            wait_ff <= 2'h0;
            o_mem_rdata <= i_mem.we ? ~o_mem_rdata : mem[i_mem.addr];
            if (i_mem.we)
                mem[i_mem.addr] <= i_mem.wdata;
        end
        else
        begin
            o_mem_ack <= 1'b0;
            wait_ff <= i_mem.req ? wait_ff + 2'h1 : 2'h0;
            o_mem_rdata <= ~o_mem_rdata;
        end
    end
endmodule

// ### test/test_tlhb_top.sv
// Self-checking bench: random block layout, integer expectations.
// Assumes the memory model is compiled before this file.
`timescale 1ns/1ns
module test_tlhb_top;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [3:0] i_reg_addr = 4'h0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [1:0] i_chain_adv = 2'h0;
    logic [10:0] i_evt = 11'h000;
    logic [1:0] lat = 2'h0;
    logic [1:0] i_chain_poll = 2'h0;
    logic [1:0] i_frame_end = 2'h0;
    logic [7:0] o_rx_frame_ovh;
    logic [1:0] o_frame_overflow;
    logic i_mem_ack, o_interrupt_output, o_rx_next_valid_flag, o_tx_next_valid_flag;
    logic [7:0] i_mem_rdata, o_reg_rdata, rd;
    logic [7:0] cb [16];
    logic [10:0] o_buf_bytes, o_buf_payload;
    logic [15:0] o_rx_next, o_tx_next, cbp;
    tlhb_pkg::tlhb_mem_req_t o_mem;
    logic [31:0] rnd = 32'ha6e8c37a;
    logic evt_ok = 1'b0;
    int n_mismatch = 0;
    int checks = 0;
    int size;
    always #5 i_ref_clk = ~i_ref_clk;
    tlhb_top u_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_mem(o_mem), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .i_chain_adv(i_chain_adv), .i_chain_poll(i_chain_poll),
        .i_frame_end(i_frame_end), .i_evt(i_evt), .o_interrupt_output(o_interrupt_output),
        .o_buf_bytes(o_buf_bytes), .o_buf_payload(o_buf_payload), .o_rx_next(o_rx_next),
        .o_tx_next(o_tx_next), .o_rx_next_valid_flag(o_rx_next_valid_flag),
        .o_tx_next_valid_flag(o_tx_next_valid_flag), .o_rx_frame_ovh(o_rx_frame_ovh),
        .o_frame_overflow(o_frame_overflow));
    tlhb_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_mem(o_mem),
        .i_lat(lat), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // One register access; rdata is sampled once it has surely landed
    task automatic reg_io(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_reg_wr = wr;
        i_reg_rd = !wr;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_ref_clk);
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        @(negedge i_ref_clk);
        rd = o_reg_rdata;
    endtask
    // Pulse strobes at a random memory latency, then wait for a quiet port
    task automatic kick(input logic [1:0] adv, input logic [10:0] evt);
        int i;
        int idle;
        rnd = lfsr(rnd);
        @(negedge i_ref_clk);
        lat = rnd[1:0];
        i_chain_adv = adv;
        i_evt = evt;
        @(negedge i_ref_clk);
        i_chain_adv = 2'h0;
        i_evt = 11'h000;
        idle = 0;
        for (i = 0; i < 400 && idle < 6; i++)
        begin
            @(negedge i_ref_clk);
            idle = (o_mem.req === 1'b0) ? idle + 1 : 0;
        end
        if (idle < 6)
        begin
            chk(32'h1, 32'h0);
            complete_run();
        end
    endtask
    // Poll or frame-end strobes for one cycle, then the same quiet wait
    task automatic pulse_ctl(input logic [1:0] poll, input logic [1:0] fend);
        @(negedge i_ref_clk);
        i_chain_poll = poll;
        i_frame_end = fend;
        @(negedge i_ref_clk);
        i_chain_poll = 2'h0;
        i_frame_end = 2'h0;
        kick(2'h0, 11'h000);
    endtask
    // Origin entries stay host-owned; counters stay put without events
    always @(negedge i_ref_clk)
        if (i_mem_ack === 1'b1 && ((o_mem.we && o_mem.addr - cbp < 16'h4) ||
            (!evt_ok && o_mem.addr - cbp > 16'h4 && o_mem.addr - cbp < 16'h10)))
            chk(o_mem.addr, ~o_mem.addr);
    // ****************
    // Scenarios
    // ****************
    initial
    begin
        repeat (5) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        reg_io(1'b0, 4'h4, 8'h00);
        chk({rd, o_buf_bytes}, {8'h04, 11'h040});
        $display("test reset done");
        // Block in a random slot; rx chain 4000 -> 5000 -> end, tx head zero
        rnd = lfsr(rnd);
        cbp = 16'h1000 + {4'h0, rnd[11:4], 4'h0};
        size = (rnd[19:16] + 1) * 64;
        cb = '{8'h40, 8'h00, 8'h00, 8'h00, rnd[23:16], 8'hfe, rnd[31:24], 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
        for (int k = 0; k < 16; k++)
            u_mem.mem[cbp + 16'(k)] = cb[k];
        u_mem.mem[16'h4000] = 8'h50;
        u_mem.mem[16'h4001] = 8'h00;
        u_mem.mem[16'h5000] = 8'h00;
        u_mem.mem[16'h5001] = 8'h00;
        reg_io(1'b1, 4'h1, cbp[15:8]);
        reg_io(1'b1, 4'h2, cbp[7:0]);
        reg_io(1'b1, 4'h0, 8'h00);
        kick(2'h0, 11'h000);
        chk({o_rx_next, o_rx_next_valid_flag, o_tx_next_valid_flag}, {16'h4000, 2'h2});
        chk(o_tx_next, cbp + 16'h2);
        chk({o_buf_bytes, o_buf_payload}, {11'(size), 11'(size - 2)});
        reg_io(1'b1, 4'h1, ~cbp[15:8]);
        reg_io(1'b0, 4'h1, 8'h00);
        chk(rd, cbp[15:8]);
        $display("test fetch done");
        kick(2'h1, 11'h000);
        reg_io(1'b0, 4'h3, 8'h00);
        chk({o_rx_next, rd, o_rx_next_valid_flag, o_interrupt_output}, 26'h1400007);
        chk(o_rx_frame_ovh, 8'h06);
        reg_io(1'b1, 4'h0, 8'h04);
        chk(o_interrupt_output, 1'b0);
        reg_io(1'b1, 4'h3, 8'h01);
        reg_io(1'b1, 4'h0, 8'h00);
        chk(o_interrupt_output, 1'b0);
        // Last buffer left in place while the flag is clear
        kick(2'h1, 11'h000);
        chk({o_rx_next, o_rx_next_valid_flag, o_interrupt_output}, {16'h5000, 2'h1});
        chk(o_rx_frame_ovh, 8'h08);
        pulse_ctl(2'h0, 2'h1);
        chk({o_rx_frame_ovh, o_frame_overflow}, {8'h06, 2'h0});
        reg_io(1'b1, 4'h3, 8'h01);
        $display("test rx chain done");
        u_mem.mem[cbp + 16'h2] = 8'h60;
        reg_io(1'b1, 4'h0, 8'h02);
        kick(2'h0, 11'h000);
        reg_io(1'b0, 4'h0, 8'h00);
        chk({rd, o_tx_next, o_tx_next_valid_flag}, {8'h00, 16'h6000, 1'b1});
        reg_io(1'b1, 4'h3, 8'h03);
        $display("test tx extend done");
        // Self-linked buffer: each advance adds one buffer to the tx frame
        u_mem.mem[16'h6000] = 8'h60;
        u_mem.mem[16'h6001] = 8'h00;
        for (int k = 0; k < 17; k++)
        begin
            if (k == 16)
                chk(o_frame_overflow, 2'h0);
            kick(2'h2, 11'h000);
        end
        chk({o_tx_next, o_tx_next_valid_flag, o_frame_overflow}, {16'h6000, 1'b1, 2'h2});
        u_mem.mem[16'h6000] = 8'h00;
        kick(2'h2, 11'h000);
        chk({o_tx_next, o_tx_next_valid_flag}, {16'h6000, 1'b0});
        u_mem.mem[16'h6000] = 8'h70;
        pulse_ctl(2'h2, 2'h0);
        chk({o_tx_next, o_tx_next_valid_flag}, {16'h7000, 1'b1});
        $display("test tx frame done");
        evt_ok = 1'b1;
        kick(2'h0, 11'h401);
        chk({u_mem.mem[cbp + 16'h5], u_mem.mem[cbp + 16'hf]}, 16'hffff);
        chk(u_mem.mem[cbp + 16'h6], cb[6]);
        $display("test counters done");
        complete_run();
    end
endmodule
